// *** tfd_dl_mux.sv ***
`timescale 1ns/10ps
`default_nettype none
module tfd_dl_mux (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic [1:0]         sel,
   input  wire tfd_pkg::tfd_tx_src_t src,
   input  wire logic               ser_bit,
   input  wire logic               ovh_bit,
   output var  logic               dl_bit_r
);
   // ------------------------------------------------------------
   // Source selection
   // ------------------------------------------------------------
   wire logic lapd_path;
   wire logic pick;

   // Single controller input: no other controller can reach the bits
   assign lapd_path = src.legacy_mode ? src.legacy_bit : src.lapd1_bit; // [RL1] [RL2]
   assign pick = (sel == tfd_pkg::DL_SRC_LAPD) ? lapd_path :            // [RL1]
                 (sel == tfd_pkg::DL_SRC_SER)  ? ser_bit :              // [RL3]
                 (sel == tfd_pkg::DL_SRC_OVH)  ? ovh_bit :              // [RL4]
                 1'b1;                                                  // [RL5]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dl_bit_r <= 1'b1;
      end else if (src.dl_stb) begin
         dl_bit_r <= pick;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_src_lapd: assert property (@(posedge clk) disable iff (!rst_n) // [RL1]
      (src.dl_stb && sel == tfd_pkg::DL_SRC_LAPD)
      |=> dl_bit_r == $past(src.legacy_mode ? src.legacy_bit : src.lapd1_bit))
      else $error("lapd source bit not forwarded");
   a_src_serial: assert property (@(posedge clk) disable iff (!rst_n) // [RL3]
      (src.dl_stb && sel == tfd_pkg::DL_SRC_SER) |=> dl_bit_r == $past(ser_bit))
      else $error("serial source bit not forwarded");
   a_src_ovh: assert property (@(posedge clk) disable iff (!rst_n) // [RL4]
      (src.dl_stb && sel == tfd_pkg::DL_SRC_OVH) |=> dl_bit_r == $past(ovh_bit))
      else $error("overhead source bit not forwarded");
   a_src_ones: assert property (@(posedge clk) disable iff (!rst_n) // [RL5]
      (src.dl_stb && sel == tfd_pkg::DL_SRC_ONES) |=> dl_bit_r)
      else $error("forced ones source not one");
endmodule
`default_nettype wire

// *** tfd_line_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Receive line: framing bits with optional errors
// ------------------------------------------------------------
module tfd_line_model (
   input  wire logic           mclk,
   input  wire logic           resetn,
   input  wire logic           align,
   input  wire logic           crc_ok,
   input  wire logic           err_on,
   output var  tfd_pkg::tfd_rx_frm_t rx_frm
);
   logic [1:0] ph_r;
   logic       stb;
   // One framing bit every four clocks, so error bursts are spaced
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) ph_r <= 2'h0;
      else ph_r <= ph_r + 2'h1;
   end
   assign stb = (ph_r == 2'h3);
   assign rx_frm = {align, crc_ok, 1'b1, stb, stb & err_on};
endmodule
`default_nettype wire

// *** tfd_lof_mon.sv ***
`timescale 1ns/10ps
`default_nettype none
module tfd_lof_mon (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       en,
   input  wire logic       fbit_stb,
   input  wire logic       fbit_err,
   input  wire logic [2:0] tol,
   input  wire logic [2:0] win,
   output var  logic       lof_r
);
   // ------------------------------------------------------------
   // Windowed error count
   // ------------------------------------------------------------
   logic [2:0] bit_cnt_r;
   logic [2:0] err_cnt_r;
   wire logic       armed;
   wire logic [2:0] bits_inc;
   wire logic [2:0] errs_inc;
   wire logic       hit_tol;
   wire logic       win_end;

   // A zero tolerance would declare on every errored bit, so a zero field disarms the count
   assign armed    = en & (tol != 3'h0) & (win != 3'h0); // [RL10] [RL11] [RL14]
   assign bits_inc = bit_cnt_r + 3'h1;
   assign errs_inc = err_cnt_r + {2'h0, fbit_err};
   assign hit_tol  = fbit_err & (errs_inc >= tol);       // [RL9]
   assign win_end  = bits_inc >= win;                    // [RL9]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_r <= 3'h0;
         err_cnt_r <= 3'h0;
         lof_r     <= 1'b0;
      end else begin
         lof_r <= 1'b0;
         if (!armed) begin
            bit_cnt_r <= 3'h0;
            err_cnt_r <= 3'h0;
         end else if (fbit_stb) begin
            if (hit_tol || win_end) begin
               lof_r     <= hit_tol;
               bit_cnt_r <= 3'h0;
               err_cnt_r <= 3'h0;
            end else begin
               bit_cnt_r <= bits_inc;
               err_cnt_r <= errs_inc;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_lof_tol_block: assert property (@(posedge clk) disable iff (!rst_n) // [RL10]
      ($past(tol) == 3'h0) |-> !lof_r)
      else $error("lof declared with zero tolerance");
   a_lof_win_block: assert property (@(posedge clk) disable iff (!rst_n) // [RL11]
      ($past(win) == 3'h0) |-> !lof_r)
      else $error("lof declared with zero window");
   a_lof_cause: assert property (@(posedge clk) disable iff (!rst_n) // [RL9]
      lof_r |-> $past(fbit_stb && fbit_err && en))
      else $error("lof without a framing bit error");
   a_lof_single: assert property (@(posedge clk) disable iff (!rst_n) // [RL9]
      (fbit_stb && fbit_err && armed && tol == 3'h1) |=> lof_r)
      else $error("lof missed at tolerance one");
endmodule
`default_nettype wire

// *** tfd_pkg.sv ***
`default_nettype none
package tfd_pkg;
   // ------------------------------------------------------------
   // Register map, word indices (byte address is four times)
   // ------------------------------------------------------------
   localparam int unsigned AXI_AW        = 12;
   localparam logic [9:0]  IDX_TX_DL_SEL = 10'h10a;
   localparam logic [9:0]  IDX_FRM_CTRL  = 10'h10b;
   localparam logic [9:0]  IDX_IRQ_STS   = 10'h10e;
   localparam logic [9:0]  IDX_IRQ_MASK  = 10'h10f;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int unsigned DL_SEL_LSB     = 0;
   localparam int unsigned FC_REFRAME_BIT = 7;
   localparam int unsigned FC_CRC_BIT     = 6;
   localparam int unsigned FC_TOL_LSB     = 3;
   localparam int unsigned FC_WIN_LSB     = 0;
   localparam logic [1:0]  TX_DL_SEL_RST  = 2'h0;
   localparam logic [7:0]  FRM_CTRL_RST   = 8'h43;
   localparam int unsigned IRQ_LOF_BIT    = 0;
   localparam int unsigned IRQ_SYNC_BIT   = 1;
   localparam int unsigned IRQ_W          = 2;
   localparam logic [1:0]  IRQ_MASK_RST   = 2'h0;

   // ------------------------------------------------------------
   // Encodings
   // ------------------------------------------------------------
   localparam logic [1:0] DL_SRC_LAPD = 2'h0;
   localparam logic [1:0] DL_SRC_SER  = 2'h1;
   localparam logic [1:0] DL_SRC_OVH  = 2'h2;
   localparam logic [1:0] DL_SRC_ONES = 2'h3;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [0:0] {TFD_HUNT, TFD_SYNC} tfd_align_st_t;

   typedef struct packed {
      logic       reframe;
      logic       crc_en;
      logic [2:0] tol;
      logic [2:0] win;
   } tfd_frm_ctrl_t;

   typedef struct packed {
      logic align_found;
      logic crc_ok;
      logic esf_mode;
      logic fbit_stb;
      logic fbit_err;
   } tfd_rx_frm_t;

   typedef struct packed {
      logic dl_stb;
      logic lapd1_bit;
      logic legacy_bit;
      logic legacy_mode;
   } tfd_tx_src_t;
endpackage
`default_nettype wire

// *** tfd_top.sv ***
// Function
// RL1: Source 00 sends controller one or legacy buffer
// RL2: Only controller one reaches data link bits
// RL3: Source 01 sends transmit serial input bits
// RL4: Source 10 sends transmit overhead input bits
// RL5: Source 11 forces every data link bit one
// RL6: Rising force bit restarts receive synchronization
// RL7: Hardware clears force bit on regained sync
// RL8: CRC bit gates in-frame in extended superframe
// RL9: Lof when errors reach tolerance within window
// RL10: Zero tolerance value is blocked internally
// RL11: Zero window value is blocked internally
// RL12: Software should program tolerance of two
// RL13: Software should program window of five
// RL14: Zero fields suppress lof until both nonzero
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module tfd_top (
   input  wire logic                     mclk,
   input  wire logic                     resetn,
   input  wire logic [11:0]              s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output var  logic                     s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output var  logic                     s_axi_wready,
   output var  logic [1:0]               s_axi_bresp,
   output var  logic                     s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [11:0]              s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output var  logic                     s_axi_arready,
   output var  logic [31:0]              s_axi_rdata,
   output var  logic [1:0]               s_axi_rresp,
   output var  logic                     s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   input  wire tfd_pkg::tfd_tx_src_t     tx_src,
   input  wire logic                     tx_serial_in,
   input  wire logic                     tx_overhead_in,
   output var  logic                     tx_dl_bit,
   input  wire tfd_pkg::tfd_rx_frm_t     rx_frm,
   output var  logic                     rx_restart,
   output var  logic                     rx_in_frame,
   output var  logic                     rx_lof,
   output var  logic                     irq
);
   // ------------------------------------------------------------
   // Reset release and pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] rst_sync_r;
   wire logic  rst_n;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   wire logic [1:0] pin_raw;
   wire logic [1:0] pin_sync;
   assign pin_raw = {tx_overhead_in, tx_serial_in};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
         logic [1:0] sync_r;
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               sync_r <= 2'h0;
            end else begin
               sync_r <= {sync_r[0], pin_raw[gi]};
            end
         end
         assign pin_sync[gi] = sync_r[1];
      end
   endgenerate

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
      hit = (a[11:2] == idx);
   endfunction

   // ------------------------------------------------------------
   // Write channel
   // ------------------------------------------------------------
   logic        aw_full_r;
   logic        w_full_r;
   logic [11:0] awaddr_r;
   logic [7:0]  wdata_r;
   logic        wlane_r;
   logic        awready_r;
   logic        wready_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;

   wire logic aw_hs;
   wire logic w_hs;
   wire logic do_wr;
   wire logic aw_full_nxt;
   wire logic w_full_nxt;
   wire logic bvalid_nxt;
   wire logic wr_dl;
   wire logic wr_fc;
   wire logic wr_mask;
   wire logic wr_known;

   assign aw_hs       = s_axi_awvalid & awready_r;
   assign w_hs        = s_axi_wvalid & wready_r;
   assign do_wr       = aw_full_r & w_full_r & ~bvalid_r;
   assign aw_full_nxt = (aw_full_r | aw_hs) & ~do_wr;
   assign w_full_nxt  = (w_full_r | w_hs) & ~do_wr;
   assign bvalid_nxt  = do_wr | (bvalid_r & ~s_axi_bready);
   assign wr_known    = hit(awaddr_r, tfd_pkg::IDX_TX_DL_SEL) | hit(awaddr_r, tfd_pkg::IDX_FRM_CTRL) |
                        hit(awaddr_r, tfd_pkg::IDX_IRQ_STS) | hit(awaddr_r, tfd_pkg::IDX_IRQ_MASK);
   assign wr_dl       = do_wr & wlane_r & hit(awaddr_r, tfd_pkg::IDX_TX_DL_SEL);
   assign wr_fc       = do_wr & wlane_r & hit(awaddr_r, tfd_pkg::IDX_FRM_CTRL);
   assign wr_mask     = do_wr & wlane_r & hit(awaddr_r, tfd_pkg::IDX_IRQ_MASK);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         awaddr_r  <= 12'h000;
         wdata_r   <= 8'h00;
         wlane_r   <= 1'b0;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= tfd_pkg::RESP_OKAY;
      end else begin
         aw_full_r <= aw_full_nxt;
         w_full_r  <= w_full_nxt;
         awready_r <= ~aw_full_nxt & ~bvalid_nxt;
         wready_r  <= ~w_full_nxt & ~bvalid_nxt;
         bvalid_r  <= bvalid_nxt;
         if (aw_hs) begin
            awaddr_r <= s_axi_awaddr;
         end
         if (w_hs) begin
            wdata_r <= s_axi_wdata[7:0];
            wlane_r <= s_axi_wstrb[0];
         end
         if (do_wr) begin
            bresp_r <= wr_known ? tfd_pkg::RESP_OKAY : tfd_pkg::RESP_SLVERR;
         end
      end
   end

   // ------------------------------------------------------------
   // Control registers and alignment state
   // ------------------------------------------------------------
   logic [1:0]             dl_sel_r;
   tfd_pkg::tfd_frm_ctrl_t fc_r;
   tfd_pkg::tfd_align_st_t st_r;
   tfd_pkg::tfd_align_st_t st_nxt;
   logic                   restart_r;
   logic                   in_frame_r;
   logic                   lof_lvl_r;

   wire logic force_ev;
   wire logic crc_need;
   wire logic align_ok;
   wire logic sync_ev;
   wire logic lof_pulse;
   wire logic lof_ev;

   // Only a written 0-to-1 edge counts; rewriting a set bit does nothing
   assign force_ev = wr_fc & wdata_r[tfd_pkg::FC_REFRAME_BIT] & ~fc_r.reframe; // [RL6]
   assign crc_need = fc_r.crc_en & rx_frm.esf_mode;                           // [RL8]
   assign align_ok = rx_frm.align_found & (~crc_need | rx_frm.crc_ok);        // [RL8]
   assign sync_ev  = (st_r == tfd_pkg::TFD_HUNT) & ~force_ev & align_ok;
   assign lof_ev   = (st_r == tfd_pkg::TFD_SYNC) & lof_pulse;

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         tfd_pkg::TFD_HUNT: begin
            if (sync_ev) begin
               st_nxt = tfd_pkg::TFD_SYNC;
            end
         end
         tfd_pkg::TFD_SYNC: begin
            if (force_ev || lof_pulse) begin
               st_nxt = tfd_pkg::TFD_HUNT; // [RL6] [RL9]
            end
         end
         default: begin
            st_nxt = tfd_pkg::TFD_HUNT;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dl_sel_r   <= tfd_pkg::TX_DL_SEL_RST;
         fc_r       <= tfd_pkg::FRM_CTRL_RST;
         st_r       <= tfd_pkg::TFD_HUNT;
         restart_r  <= 1'b0;
         in_frame_r <= 1'b0;
         lof_lvl_r  <= 1'b0;
      end else begin
         st_r       <= st_nxt;
         restart_r  <= force_ev | lof_ev; // [RL6]
         in_frame_r <= (st_nxt == tfd_pkg::TFD_SYNC);
         if (wr_dl) begin
            dl_sel_r <= wdata_r[tfd_pkg::DL_SEL_LSB +: 2];
         end
         if (wr_fc) begin
            fc_r <= wdata_r;
         end else if (sync_ev) begin
            fc_r.reframe <= 1'b0; // [RL7]
         end
         if (lof_ev) begin
            lof_lvl_r <= 1'b1;
         end else if (sync_ev) begin
            lof_lvl_r <= 1'b0;
         end
      end
   end

   tfd_lof_mon u_lof (
      .clk      (mclk),
      .rst_n    (rst_n),
      .en       (st_r == tfd_pkg::TFD_SYNC),
      .fbit_stb (rx_frm.fbit_stb),
      .fbit_err (rx_frm.fbit_err),
      .tol      (fc_r.tol),
      .win      (fc_r.win),
      .lof_r    (lof_pulse)
   );

   tfd_dl_mux u_dl (
      .clk      (mclk),
      .rst_n    (rst_n),
      .sel      (dl_sel_r),
      .src      (tx_src),
      .ser_bit  (pin_sync[0]),
      .ovh_bit  (pin_sync[1]),
      .dl_bit_r (tx_dl_bit)
   );

   // ------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------
   logic [1:0] sts_r;
   logic [1:0] mask_r;
   logic       irq_r;
   wire logic       ar_hs;
   wire logic       rd_sts;
   wire logic [1:0] sts_set;
   wire logic [1:0] sts_nxt;
   wire logic [1:0] mask_nxt;

   assign ar_hs    = s_axi_arvalid & s_axi_arready;
   assign rd_sts   = ar_hs & hit(s_axi_araddr, tfd_pkg::IDX_IRQ_STS);
   assign sts_set  = {sync_ev, lof_ev};
   // A new event in the clearing read cycle survives the clear
   assign sts_nxt  = (sts_r & {2{~rd_sts}}) | sts_set;
   assign mask_nxt = wr_mask ? wdata_r[tfd_pkg::IRQ_W-1:0] : mask_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sts_r  <= 2'h0;
         mask_r <= tfd_pkg::IRQ_MASK_RST;
         irq_r  <= 1'b0;
      end else begin
         sts_r  <= sts_nxt;
         mask_r <= mask_nxt;
         irq_r  <= |(sts_nxt & mask_nxt);
      end
   end

   // ------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------
   logic        arready_r;
   logic        rvalid_r;
   logic [7:0]  rbyte_r;
   logic [1:0]  rresp_r;
   wire logic       rvalid_nxt;
   wire logic       rd_known;
   wire logic [7:0] rd_byte;

   assign rvalid_nxt = ar_hs | (rvalid_r & ~s_axi_rready);
   assign rd_byte  = hit(s_axi_araddr, tfd_pkg::IDX_TX_DL_SEL) ? {6'h00, dl_sel_r} :
                     hit(s_axi_araddr, tfd_pkg::IDX_FRM_CTRL)  ? fc_r :
                     hit(s_axi_araddr, tfd_pkg::IDX_IRQ_STS)   ? {6'h00, sts_r} :
                     hit(s_axi_araddr, tfd_pkg::IDX_IRQ_MASK)  ? {6'h00, mask_r} : 8'h00;
   assign rd_known = hit(s_axi_araddr, tfd_pkg::IDX_TX_DL_SEL) | hit(s_axi_araddr, tfd_pkg::IDX_FRM_CTRL) |
                     hit(s_axi_araddr, tfd_pkg::IDX_IRQ_STS) | hit(s_axi_araddr, tfd_pkg::IDX_IRQ_MASK);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rbyte_r   <= 8'h00;
         rresp_r   <= tfd_pkg::RESP_OKAY;
      end else begin
         arready_r <= ~rvalid_nxt;
         rvalid_r  <= rvalid_nxt;
         if (ar_hs) begin
            rbyte_r <= rd_byte;
            rresp_r <= rd_known ? tfd_pkg::RESP_OKAY : tfd_pkg::RESP_SLVERR;
         end
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = {24'h000000, rbyte_r};
   assign s_axi_rresp   = rresp_r;
   assign rx_restart    = restart_r;
   assign rx_in_frame   = in_frame_r;
   assign rx_lof        = lof_lvl_r;
   assign irq           = irq_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_force_restart: assert property (@(posedge mclk) disable iff (!rst_n) // [RL6]
      force_ev |=> rx_restart && !rx_in_frame)
      else $error("force reframe did not restart");
   a_reframe_clear: assert property (@(posedge mclk) disable iff (!rst_n) // [RL7]
      sync_ev |=> rx_in_frame && (!fc_r.reframe || $past(wr_fc)))
      else $error("force bit not cleared on sync");
   a_crc_gate: assert property (@(posedge mclk) disable iff (!rst_n) // [RL8]
      (st_r == tfd_pkg::TFD_HUNT && crc_need && !rx_frm.crc_ok) |=> !rx_in_frame)
      else $error("in frame without crc");
   a_lof_drop: assert property (@(posedge mclk) disable iff (!rst_n) // [RL9]
      lof_ev |=> rx_lof && !rx_in_frame && rx_restart)
      else $error("lof did not drop alignment");
   a_irq_level: assert property (@(posedge mclk) disable iff (!rst_n)
      irq == |(sts_r & mask_r))
      else $error("irq not matching masked status");
   a_bvalid_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("bvalid dropped early");
endmodule
`default_nettype wire

// *** tfd_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tfd_top_tb;
   localparam logic [11:0] A_DL  = {tfd_pkg::IDX_TX_DL_SEL, 2'h0};
   localparam logic [11:0] A_FC  = {tfd_pkg::IDX_FRM_CTRL, 2'h0};
   localparam logic [11:0] A_STS = {tfd_pkg::IDX_IRQ_STS, 2'h0};
   localparam logic [11:0] A_MSK = {tfd_pkg::IDX_IRQ_MASK, 2'h0};
   localparam logic [1:0]  OK    = tfd_pkg::RESP_OKAY;
   logic        mclk = 1'b0, resetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'h1;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        tx_serial_in = 1'b0, tx_overhead_in = 1'b0, tx_dl_bit, rx_restart, rx_in_frame, rx_lof, irq;
   logic        align = 1'b0, crc_ok = 1'b0, err_on = 1'b0;
   tfd_pkg::tfd_tx_src_t tx_src = '0;
   tfd_pkg::tfd_rx_frm_t rx_frm;
   int          error_cnt = 0, n_compared = 0, rst_cnt = 0, s, v;

   always #12.5 mclk = ~mclk;
   always @(negedge mclk) if (rx_restart === 1'b1) rst_cnt++;

   tfd_top DUT (.mclk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_src, .tx_serial_in,
      .tx_overhead_in, .tx_dl_bit, .rx_frm, .rx_restart, .rx_in_frame, .rx_lof, .irq);
   tfd_line_model LINE (.mclk, .resetn, .align, .crc_ok, .err_on, .rx_frm);

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic test_done;
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic nw(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   // Handshakes are judged at the falling edge, where readies are settled
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      int i;
      logic ha, hw;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(negedge mclk);
         ha = s_axi_awvalid & s_axi_awready;
         hw = s_axi_wvalid & s_axi_wready;
         if (s_axi_bvalid === 1'b1) break;
         @(posedge mclk);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
      end
      if (i == 50) begin
         error_cnt++;
         test_done();
      end
      chk(s_axi_bresp, OK);
      @(posedge mclk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      int i;
      logic ha;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(negedge mclk);
         ha = s_axi_arvalid & s_axi_arready;
         if (s_axi_rvalid === 1'b1) break;
         @(posedge mclk);
         if (ha) s_axi_arvalid <= 1'b0;
      end
      if (i == 50) begin
         error_cnt++;
         test_done();
      end
      chk(s_axi_rdata, exp);
      chk(s_axi_rresp, er);
      @(posedge mclk);
      s_axi_rready <= 1'b0;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      rd(A_FC, 32'h43, OK);
      rd(A_DL, 32'h0, OK);
      rd(12'h440, 32'h0, tfd_pkg::RESP_SLVERR);
      $display("Test registers done");
      // Target source carries v, every other source carries its inverse
      for (s = 0; s < 5; s++) for (v = 0; v < 2; v++) begin
         wr(A_DL, {6'h00, s[1:0]});
         @(posedge mclk);
         tx_src <= {1'b0, (s == 0) == v[0], (s == 4) == v[0], s == 4};
         tx_serial_in <= (s == 1) == v[0];
         tx_overhead_in <= (s == 2) == v[0];
         repeat (3) @(posedge mclk);
         tx_src.dl_stb <= 1'b1;
         @(posedge mclk);
         tx_src.dl_stb <= 1'b0;
         @(negedge mclk);
         chk(tx_dl_bit, (s == 3) ? 1'b1 : v[0]);
      end
      $display("Test data link done");
      @(posedge mclk);
      align <= 1'b1;
      nw(10);
      chk(rx_in_frame, 1'b0);
      wr(A_FC, 8'h15);
      nw(3);
      chk(rx_in_frame, 1'b1);
      chk(irq, 1'b0);
      wr(A_MSK, 8'h03);
      nw(1);
      chk(irq, 1'b1);
      rd(A_STS, 32'h2, OK);
      nw(1);
      chk(irq, 1'b0);
      $display("Test alignment done");
      @(posedge mclk);
      align <= 1'b0;
      wr(A_FC, 8'h95);
      wr(A_FC, 8'h95);
      nw(2);
      chk(rst_cnt, 32'h1);
      chk(rx_in_frame, 1'b0);
      rd(A_FC, 32'h95, OK);
      @(posedge mclk);
      align <= 1'b1;
      nw(3);
      chk(rx_in_frame, 1'b1);
      rd(A_FC, 32'h15, OK);
      rd(A_STS, 32'h2, OK);
      $display("Test reframe done");
      @(posedge mclk);
      align <= 1'b0;
      err_on <= 1'b1;
      nw(3);
      chk(rx_lof, 1'b0);
      nw(9);
      chk(rx_lof, 1'b1);
      chk(rx_in_frame, 1'b0);
      chk(rst_cnt, 32'h2);
      rd(A_STS, 32'h1, OK);
      @(posedge mclk);
      err_on <= 1'b0;
      align <= 1'b1;
      wr(A_FC, 8'h05);
      nw(3);
      chk(rx_lof, 1'b0);
      @(posedge mclk);
      align <= 1'b0;
      err_on <= 1'b1;
      nw(40);
      chk(rx_lof, 1'b0);
      wr(A_FC, 8'h10);
      nw(40);
      chk(rx_lof, 1'b0);
      wr(A_FC, 8'h15);
      nw(12);
      chk(rx_lof, 1'b1);
      $display("Test loss of frame done");
      // Checking on, tolerance one: sync waits for good check values
      @(posedge mclk);
      err_on <= 1'b0;
      wr(A_FC, 8'h4d);
      @(posedge mclk);
      align <= 1'b1;
      nw(6);
      chk(rx_in_frame, 1'b0);
      @(posedge mclk);
      crc_ok <= 1'b1;
      nw(3);
      chk(rx_in_frame, 1'b1);
      chk(rx_lof, 1'b0);
      @(posedge mclk);
      align <= 1'b0;
      err_on <= 1'b1;
      nw(7);
      chk(rx_lof, 1'b1);
      chk(rx_in_frame, 1'b0);
      $display("Test crc gate done");
      test_done();
   end
endmodule
`default_nettype wire
